// >>> verilog/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// ==========================================
// Timing
`define ACS_CLK_PERIOD_PS 10000
`define ACS_WAKE_TIME_PS 1000000
`define ACS_WAKE_CYCLES (`ACS_WAKE_TIME_PS / `ACS_CLK_PERIOD_PS)
`define ACS_SETTLE_TIME_PS 135000
`define ACS_SETTLE_CYCLES ((`ACS_SETTLE_TIME_PS + `ACS_CLK_PERIOD_PS - 1) / `ACS_CLK_PERIOD_PS)
`define ACS_CONV_TIME_PS 531660
`define ACS_CONV_CYCLES (`ACS_CONV_TIME_PS / `ACS_CLK_PERIOD_PS)
// ==========================================
// Reset values
`define ACS_RESULT_RST 16'h0000
`endif

// >>> verilog/acs_pkg.sv
package acs_pkg;
  // ==========================================
  // Types
  typedef enum logic [1:0] {ACS_AWAKE, ACS_CONVERT, ACS_SLEEP, ACS_WAKE} acs_state_e;
  typedef struct packed {
    logic convert_start_n;
    logic chip_select_n;
    logic read_n;
  } acs_ctrl_s;
endpackage : acs_pkg

// >>> verilog/acs_counter.sv
`timescale 1ns/10ps
// Down counter; done when zero and not loading
module acs_counter #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign done = (cnt_q == '0) && !load;
endmodule : acs_counter

// >>> verilog/acs_sleep_ctrl.sv
`timescale 1ns/10ps
`include "acs_defines.svh"
// ==========================================
// Contract
// - Start re-pulsed during busy abandons conversion and restarts it.
// - At busy fall, low convert_start_n means sleep, else stay awake.
// - Sleeping device wakes on start rising edge, then waits 1 us.
// - Busy rises only on start falling, never on wake edge alone.
// - Start falling during wake-up is held until wake-up completes.
// - Approximation steps begin on first clock after busy asserts.
// - Busy lasts 531.66 ns conversion time at 26 MHz, 12 bits; here busy lasts CONV_CYCLES + 1 = 54 clocks of 10 ns, 540 ns.
// - High-speed mode: stay awake; host waits 135 ns after busy falls.
// - Data driven only while chip_select_n and read_n both low.
// - Result is straight binary, 10 or 12 bits wide.
module acs_sleep_ctrl
  import acs_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int WAKE_CYCLES = `ACS_WAKE_CYCLES,
  parameter int CONV_CYCLES = `ACS_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire acs_ctrl_s ctrl,
  input wire logic [DATA_W-1:0] sample_data,
  output logic busy,
  output logic asleep,
  output logic settling,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n
);
  localparam int CW = 8;
  localparam int CLW = CW + 1;
  localparam int WW = $clog2(WAKE_CYCLES + 1);
  localparam int SW = $clog2(`ACS_SETTLE_CYCLES + 1);

  // ==========================================
  // Edge decode
  logic cs_q;
  logic pend_q;
  acs_state_e state_q;
  acs_state_e state_d;
  logic [DATA_W-1:0] sample_q;
  logic [DATA_W-1:0] result_q;
  wire start_fall = cs_q && !ctrl.convert_start_n;
  wire start_rise = !cs_q && ctrl.convert_start_n;
  wire conv_done;
  wire wake_done;
  wire settle_done;
  wire in_conv = (state_q == ACS_CONVERT);
  wire conv_load = start_fall && (state_q == ACS_AWAKE || in_conv);
  wire wake_load = (state_q == ACS_SLEEP) && start_rise;
  wire finish = in_conv && conv_done && !start_fall;
  wire go_sleep = finish && !ctrl.convert_start_n;
  wire start_after_wake = (state_q == ACS_WAKE) && wake_done && (pend_q || start_fall);
  wire read_en = !ctrl.chip_select_n && !ctrl.read_n;

  // A restart reloads the same counter, so the full conversion time runs again
  acs_counter #(.W(CW)) u_conv (
    .clk(clk),
    .rst_n(rst_n),
    .load(conv_load || start_after_wake),
    .value(CW'(CONV_CYCLES)),
    .done(conv_done)
  );
  acs_counter #(.W(WW)) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .load(wake_load),
    .value(WW'(WAKE_CYCLES)),
    .done(wake_done)
  );
  // Settling is advisory only; a start during it is still taken
  acs_counter #(.W(SW)) u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .load(finish),
    .value(SW'(`ACS_SETTLE_CYCLES)),
    .done(settle_done)
  );

  // ==========================================
  // State selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      ACS_AWAKE: if (conv_load) state_d = ACS_CONVERT;
      ACS_CONVERT: begin
        if (go_sleep) begin
          state_d = ACS_SLEEP;
        end else if (finish) begin
          state_d = ACS_AWAKE;
        end
      end
      ACS_SLEEP: if (wake_load) state_d = ACS_WAKE;
      ACS_WAKE: begin
        if (start_after_wake) begin
          state_d = ACS_CONVERT;
        end else if (wake_done) begin
          state_d = ACS_AWAKE; // Awake but idle: no busy on wake alone
        end
      end
      default: state_d = ACS_AWAKE;
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      pend_q <= 1'b0;
      state_q <= ACS_AWAKE;
      sample_q <= '0;
      result_q <= DATA_W'(`ACS_RESULT_RST);
      busy <= 1'b0;
      asleep <= 1'b0;
      settling <= 1'b0;
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      cs_q <= ctrl.convert_start_n;
      pend_q <= (state_q == ACS_WAKE) && !start_after_wake && (pend_q || start_fall);
      state_q <= state_d;
      if (conv_load || start_after_wake) sample_q <= sample_data;
      if (finish) result_q <= sample_q;
      busy <= (state_d == ACS_CONVERT);
      asleep <= (state_d == ACS_SLEEP);
      settling <= finish || !settle_done;
      data_out <= finish ? sample_q : result_q;
      data_oe_n <= !read_en;
    end
  end

  // ==========================================
  // Check helpers
  // Busy run length; cleared at each start so a restart is measured afresh
  logic [CLW-1:0] busy_len_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_len_q <= '0;
    end else if (conv_load || start_after_wake) begin
      busy_len_q <= '0;
    end else if (busy) begin
      busy_len_q <= busy_len_q + 1'b1;
    end
  end

  // ==========================================
  // Conversion checks
  busy_on_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_AWAKE && start_fall) |=> busy)
    else $error("busy not raised after start");
  busy_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> $past(start_fall || pend_q))
    else $error("busy rose without a start");
  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_conv && !finish) |=> busy)
    else $error("busy dropped early");
  busy_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    finish |-> busy_len_q == CLW'(CONV_CYCLES))
    else $error("busy length wrong");
  sample_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    (conv_load || start_after_wake) |=> sample_q == $past(sample_data))
    else $error("sample not taken at start");
  restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_conv && start_fall) |=> busy ##1 busy)
    else $error("restart dropped busy");
  restart_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_conv && start_fall) |=> busy_len_q == '0)
    else $error("restart did not reload");

  // ==========================================
  // Sleep and wake checks
  sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    go_sleep |=> asleep && !busy)
    else $error("sleep not entered");
  stay_awake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (finish && ctrl.convert_start_n) |=> !asleep && !busy)
    else $error("slept in high-speed mode");
  sleep_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    asleep |-> !busy)
    else $error("busy while asleep");
  sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_SLEEP && !start_rise) |=> asleep)
    else $error("woke without rising start");
  wake_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_SLEEP && start_rise) |=> !asleep)
    else $error("rising start did not wake");
  no_wake_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_SLEEP && start_rise) |=> !busy)
    else $error("busy raised on wake edge");
  wake_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_SLEEP && start_rise) |=> !busy [*8])
    else $error("busy during wake-up");
  wake_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_WAKE && !wake_done) |=> !busy)
    else $error("conversion before wake-up ended");
  wake_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_WAKE && start_fall && !wake_done) |=> pend_q)
    else $error("start during wake-up lost");
  wake_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ACS_WAKE && wake_done && !pend_q && !start_fall) |=> !busy && !asleep)
    else $error("wake alone started a conversion");

  // ==========================================
  // Result and bus checks
  result_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    finish |=> result_q == $past(sample_q) && data_out == $past(sample_q))
    else $error("result not loaded at end");
  result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!finish && !$past(finish)) |=> $stable(result_q))
    else $error("result changed");
  bus_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    read_en |=> !data_oe_n)
    else $error("bus not driven on read");
  bus_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl.chip_select_n || ctrl.read_n) |=> data_oe_n)
    else $error("bus driven without read");
  settle_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    finish |=> settling)
    else $error("settling not flagged");
endmodule : acs_sleep_ctrl

// >>> tb/acs_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host side of the converter
module acs_host_model
  import acs_pkg::*;
(
  input wire logic clk,
  output acs_ctrl_s ctrl
);
  initial ctrl = 3'b111;
  task automatic conv(input bit hold);
    @(posedge clk) ctrl.convert_start_n <= 1'b0;
    if (!hold) begin
      repeat (2) @(posedge clk);
      ctrl.convert_start_n <= 1'b1;
    end
  endtask : conv
  task automatic lift(input bit fall);
    @(posedge clk) ctrl.convert_start_n <= 1'b1;
    if (fall) begin
      @(posedge clk) ctrl.convert_start_n <= 1'b0;
    end
  endtask : lift
  task automatic rd(input bit en);
    @(posedge clk);
    ctrl.chip_select_n <= ~en;
    ctrl.read_n <= ~en;
  endtask : rd
endmodule : acs_host_model

// >>> tb/acs_sleep_ctrl_bench.sv
`timescale 1ns/10ps
module acs_sleep_ctrl_bench;
  import acs_pkg::*;
  localparam int W = 10;
  localparam int C = 53;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] sample_data = 12'h000;
  logic busy, asleep, settling, data_oe_n;
  logic [11:0] data_out;
  logic [15:0] lf = 16'h001A;
  acs_ctrl_s ctrl;
  int bad_count = 0;
  int checks_done = 0;
  int hi = 0;
  int k;
  int exp_q[$];
  // Free-running clock keeps the burst clock limits by construction
  always #5 clk = ~clk;
  always @(negedge clk) if (busy === 1'b1) hi++;
  acs_host_model acs_host_model_inst (.clk(clk), .ctrl(ctrl));
  acs_sleep_ctrl #(.WAKE_CYCLES(W), .CONV_CYCLES(C)) acs_sleep_ctrl_inst (.clk(clk), .rst_n(rst_n), .ctrl(ctrl),
    .sample_data(sample_data), .busy(busy), .asleep(asleep), .settling(settling), .data_out(data_out),
    .data_oe_n(data_oe_n));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // ==========================================
  // Stimulus and result checks
  task automatic go(input bit hold, input bit wake);
    lf = lfsr(lf);
    @(posedge clk) sample_data <= lf[11:0];
    exp_q.push_back(lf[11:0]);
    if (wake) acs_host_model_inst.lift(1'b1);
    else acs_host_model_inst.conv(hold);
  endtask : go
  // Zero length means a restarted, longer conversion
  task automatic finish(input int len);
    k = 0;
    while ((busy !== 1'b0 || hi == 0) && k < 500) begin
      @(negedge clk);
      k++;
    end
    if (k >= 500) bad_count++;
    @(negedge clk);
    chk("result", exp_q[$], data_out);
    chk("settling", 1, settling);
    if (len > 0) chk("busy length", len, hi);
    else chk("busy extended", 1, hi > C + 1);
    hi = 0;
    repeat (14) @(negedge clk);
    chk("settled", 0, settling);
  endtask : finish
  task automatic rdchk();
    acs_host_model_inst.rd(1'b1);
    repeat (2) @(negedge clk);
    chk("bus enable", 0, data_oe_n);
    chk("bus data", exp_q[$], data_out);
    acs_host_model_inst.rd(1'b0);
    repeat (2) @(negedge clk);
    chk("bus release", 1, data_oe_n);
  endtask : rdchk
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    go(0, 0);
    finish(C + 1);
    go(0, 0);
    finish(C + 1);
    chk("awake", 0, asleep);
    rdchk();
    rdchk();
    go(0, 0);
    repeat (8) @(posedge clk);
    go(0, 0);
    finish(0);
    go(1, 0);
    finish(C + 1);
    chk("asleep", 1, asleep);
    go(1, 1);
    k = 0;
    while (busy !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("wake gap", 1, k >= W - 1 && k <= W + 4);
    chk("woken", 0, asleep);
    finish(C + 1);
    acs_host_model_inst.lift(1'b0);
    repeat (3 * W) @(negedge clk);
    chk("busy on wake", 0, busy);
    complete_run();
  end
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
endmodule : acs_sleep_ctrl_bench
